// ===== common/uart_stat_consts.vh
// Constants for the serial unit status and baud generator block
// Contract
// - Reset clears receive error status, transmit status and divider to zero.
// - ID flag follows received appended bit: set on one, cleared otherwise.
// - ID flag changes at frame end only in multiprocessor transfer mode.
// - Parity error set when received parity disagrees with selected type.
// - Framing error set when first stop bit is not found.
// - Receiver checks only the first stop bit, even with two configured.
// - Overrun set when a frame ends before the held byte is read.
// - After overrun, new bytes are discarded until the held byte is read.
// - Clearing unit power enable clears all four receive flags.
// - Buffer-full flag set on write, cleared on move or enable loss; with two bytes held, the first move leaves it set.
// - Shifter-busy set on move, cleared at idle end or enable loss.
// - Divider value k divides prescaled clock; k below 8 is prohibited.
// - Baud rate is oscillator over two to n plus one, times k.
// - Zero parity selection skips the parity check entirely.
// - Source select zero takes the external pin, else oscillator over 2^n.
`ifndef UART_STAT_CONSTS_VH
`define UART_STAT_CONSTS_VH

// Register byte addresses
`define ADDR_BAUD_DIVIDER 16'hFF93
`define ADDR_RX_ERR_STATUS 16'hFF94
`define ADDR_TX_STATUS 16'hFF95

// Reset values
`define RST_BAUD_DIVIDER 8'h00
`define RST_RX_ERR_STATUS 8'h00
`define RST_TX_STATUS 8'h00
`define RST_RX_BUFFER 8'hFF
`define RST_TX_BUFFER 8'hFF
`define RST_READ_DATA 8'h00

// Field positions in receive error status
`define BIT_OVERRUN 0
`define BIT_FRAMING 1
`define BIT_PARITY 2
`define BIT_ID_FRAME 3

// Field positions in transmit status
`define BIT_SHIFTER_BUSY 0
`define BIT_HOLD_FULL 1

// Parity select codes
`define PAR_NONE 2'h0
`define PAR_ZERO 2'h1
`define PAR_ODD 2'h2
`define PAR_EVEN 2'h3

// Transfer mode codes
`define MODE_MULTIPROC 2'h1

// Divider limits and source select
`define DIV_MIN 8'h08
`define SRC_EXTERNAL 3'h0

`endif

// ===== core/baud_gen.v
// Prescaler and programmable divider forming the baud clock
`timescale 1ns/100ps
`default_nettype none
`include "uart_stat_consts.vh"

module baud_gen #(
	parameter PRE_W = 7
) (
	input wire clk, // System clock
	input wire srst, // Synchronous reset, active high
	input wire run, // Unit power enable
	input wire [2:0] src_sel, // Prescaler source select n
	input wire [7:0] divisor, // Divider value k
	input wire ext_clk, // Synchronised external source clock
	output reg baud_clk, // Baud clock square wave
	output reg baud_tick // One pulse per baud clock period
);

	reg [PRE_W-1:0] pre_reg;
	reg ext_dly_reg;
	reg [7:0] cnt_reg;
	reg src_tick;
	wire [PRE_W-1:0] pre_mask;
	wire k_legal;

	assign pre_mask = ~({PRE_W{1'b1}} << src_sel);
	assign k_legal = (divisor >= `DIV_MIN);

	// Source tick: external edge or oscillator over 2^n
	always @* begin
		if (src_sel == `SRC_EXTERNAL) begin
			src_tick = ext_clk & ~ext_dly_reg;
		end else begin
			src_tick = ((pre_reg & pre_mask) == pre_mask);
		end
	end

	// Prescaler counter and external edge history
	always @(posedge clk) begin
		if (srst || !run) begin
			pre_reg <= {PRE_W{1'b0}};
			ext_dly_reg <= 1'b0;
		end else begin
			pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
			ext_dly_reg <= ext_clk;
		end
	end

	// Divide by k, toggle output: rate = fx / (2^(n+1) * k)
	always @(posedge clk) begin
		if (srst || !run || !k_legal) begin
			cnt_reg <= 8'h00;
			baud_clk <= 1'b0;
			baud_tick <= 1'b0;
		end else begin
			baud_tick <= 1'b0;
			if (src_tick) begin
				if (cnt_reg == divisor - 8'h01) begin
					cnt_reg <= 8'h00;
					baud_clk <= ~baud_clk;
					baud_tick <= ~baud_clk;
				end else begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
		end
	end

endmodule // baud_gen
`default_nettype wire

// ===== core/uart_status_top.v
// Status flags, transmit buffering and baud generation of the serial unit
`timescale 1ns/100ps
`default_nettype none
`include "uart_stat_consts.vh"

module uart_status_top (
	input wire CLK_SYS, // System clock, 20 MHz
	input wire SRST, // Synchronous reset, active high
	// CPU register access
	input wire [15:0] ADDR, // Byte address
	input wire [7:0] WDATA, // Write data
	input wire WR, // Write strobe, one cycle
	input wire RD, // Read strobe, one cycle
	output reg [7:0] RDATA, // Read data, valid cycle after RD
	// Mode bits from neighbouring registers
	input wire UNIT_POWER_ENABLE, // Unit clock and power enable
	input wire TRANSMIT_ENABLE_BIT, // Transmit enable
	input wire RECEIVE_ENABLE_BIT, // Receive enable
	input wire [1:0] PARITY_SELECT, // Parity type select
	input wire CHAR_LEN_8, // High for 8-bit data, low for 7
	input wire [1:0] TRANSFER_MODE, // Transfer mode select
	input wire [2:0] SOURCE_SELECT, // Prescaler source select
	input wire EXT_CLK_PIN, // External source clock pin
	// Transmit holding buffer write
	input wire TXB_WR, // Holding buffer write strobe
	input wire [7:0] TXB_DATA, // Holding buffer write data
	output reg TXB_READY, // Holding buffer can take a byte
	// Hand-over to the transmit shifter
	output reg TX_VALID, // Byte offered to shifter
	output reg [7:0] TX_DATA, // Byte offered to shifter
	input wire TX_READY, // Shifter takes the byte
	input wire TX_SHIFT_DONE, // Shifter finished its frame
	// Frame result from the receive shifter
	input wire RX_DONE, // Frame end pulse
	input wire [7:0] RX_SHIFT_DATA, // Received data bits
	input wire RX_PARITY_BIT, // Received parity bit
	input wire RX_STOP_BIT, // First stop bit sample
	input wire RX_MP_BIT, // Multiprocessor appended bit
	// Receive holding buffer
	input wire RXB_RD, // Holding buffer read strobe
	output reg [7:0] RX_BYTE, // Holding buffer contents
	output reg RX_FULL, // Holding buffer holds unread byte
	// Baud generator
	output wire BAUD_CLK, // Baud clock
	output wire BAUD_TICK // One pulse per baud period
);

	// Register bank
	reg [7:0] divider_reg;
	reg id_frame_flag_reg;
	reg parity_error_flag_reg;
	reg framing_error_flag_reg;
	reg overrun_flag_reg;
	reg shifter_busy_reg;

	// Two-entry transmit buffer
	reg [7:0] ent1_reg;
	reg v1_reg;
	reg v0_next;
	reg v1_next;
	reg [7:0] d0_next;
	reg [7:0] d1_next;

	// External clock synchroniser
	reg ext_s1_reg;
	reg ext_s2_reg;

	// Receive checks
	reg par_err;
	reg [7:0] rx_masked;
	wire rx_xor;

	wire tx_on;
	wire rx_on;
	wire push;
	wire pop;
	wire hold_full;
	wire [7:0] rx_status;
	wire [7:0] tx_status;

	assign tx_on = UNIT_POWER_ENABLE & TRANSMIT_ENABLE_BIT;
	assign rx_on = UNIT_POWER_ENABLE & RECEIVE_ENABLE_BIT;

	// Writes refused while buffer has no room
	assign push = TXB_WR & TXB_READY & tx_on;
	assign pop = TX_VALID & TX_READY;
	assign hold_full = TX_VALID | v1_reg;

	// Status register images, upper bits read zero
	assign rx_status = {4'h0,
		id_frame_flag_reg,
		parity_error_flag_reg,
		framing_error_flag_reg,
		overrun_flag_reg};
	assign tx_status = {6'h00, hold_full, shifter_busy_reg};

	// Two flops on the external clock pin
	always @(posedge CLK_SYS) begin
		if (SRST) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
		end else begin
			ext_s1_reg <= EXT_CLK_PIN;
			ext_s2_reg <= ext_s1_reg;
		end
	end

	// Divider register write
	always @(posedge CLK_SYS) begin
		if (SRST) begin
			divider_reg <= `RST_BAUD_DIVIDER;
		end else if (WR && ADDR == `ADDR_BAUD_DIVIDER) begin
			divider_reg <= WDATA;
		end
	end

	// Read data mux, unmapped addresses read zero
	always @(posedge CLK_SYS) begin
		if (SRST) begin
			RDATA <= `RST_READ_DATA;
		end else if (RD) begin
			if (ADDR == `ADDR_BAUD_DIVIDER) begin
				RDATA <= divider_reg;
			end else if (ADDR == `ADDR_RX_ERR_STATUS) begin
				RDATA <= rx_status;
			end else if (ADDR == `ADDR_TX_STATUS) begin
				RDATA <= tx_status;
			end else begin
				RDATA <= 8'h00;
			end
		end
	end

	// Transmit buffer next state, head entry feeds shifter
	always @* begin
		v0_next = TX_VALID;
		v1_next = v1_reg;
		d0_next = TX_DATA;
		d1_next = ent1_reg;
		if (pop) begin
			v0_next = v1_reg;
			d0_next = ent1_reg;
			v1_next = 1'b0;
		end
		if (push) begin
			if (!v0_next) begin
				v0_next = 1'b1;
				d0_next = TXB_DATA;
			end else begin
				v1_next = 1'b1;
				d1_next = TXB_DATA;
			end
		end
	end

	// Transmit buffer registers, flushed when enables drop
	always @(posedge CLK_SYS) begin
		if (SRST) begin
			TX_VALID <= 1'b0;
			v1_reg <= 1'b0;
			TX_DATA <= `RST_TX_BUFFER;
			ent1_reg <= `RST_TX_BUFFER;
			TXB_READY <= 1'b0;
		end else if (!tx_on) begin
			TX_VALID <= 1'b0;
			v1_reg <= 1'b0;
			TX_DATA <= `RST_TX_BUFFER;
			ent1_reg <= `RST_TX_BUFFER;
			TXB_READY <= 1'b0;
		end else begin
			TX_VALID <= v0_next;
			v1_reg <= v1_next;
			TX_DATA <= d0_next;
			ent1_reg <= d1_next;
			TXB_READY <= ~v1_next;
		end
	end

	// Shifter busy: set on hand-over, cleared at idle frame end
	always @(posedge CLK_SYS) begin
		if (SRST) begin
			shifter_busy_reg <= 1'b0;
		end else if (!tx_on) begin
			shifter_busy_reg <= 1'b0;
		end else if (pop) begin
			shifter_busy_reg <= 1'b1;
		end else if (TX_SHIFT_DONE && !TX_VALID) begin
			shifter_busy_reg <= 1'b0;
		end
	end

	// Data masked to the configured character length
	always @* begin
		rx_masked = RX_SHIFT_DATA;
		if (!CHAR_LEN_8) begin
			rx_masked = {1'b0, RX_SHIFT_DATA[6:0]};
		end
	end

	assign rx_xor = ^rx_masked ^ RX_PARITY_BIT;

	// Parity check per selected type, none for zero parity
	always @* begin
		case (PARITY_SELECT)
			`PAR_ODD: par_err = ~rx_xor;
			`PAR_EVEN: par_err = rx_xor;
			default: par_err = 1'b0;
		endcase
	end

	// Receive flags, refreshed at each frame end, ID flag in multiprocessor mode only
	always @(posedge CLK_SYS) begin
		if (SRST) begin
			id_frame_flag_reg <= 1'b0;
			parity_error_flag_reg <= 1'b0;
			framing_error_flag_reg <= 1'b0;
			overrun_flag_reg <= 1'b0;
		end else if (!UNIT_POWER_ENABLE) begin
			id_frame_flag_reg <= 1'b0;
			parity_error_flag_reg <= 1'b0;
			framing_error_flag_reg <= 1'b0;
			overrun_flag_reg <= 1'b0;
		end else if (RX_DONE && rx_on) begin
			parity_error_flag_reg <= par_err;
			framing_error_flag_reg <= ~RX_STOP_BIT;
			// Unread byte still held: this frame overruns
			overrun_flag_reg <= RX_FULL && !RXB_RD;
			if (TRANSFER_MODE == `MODE_MULTIPROC) begin
				id_frame_flag_reg <= RX_MP_BIT;
			end
		end
	end

	// Receive holding buffer, new byte dropped while unread
	always @(posedge CLK_SYS) begin
		if (SRST || !UNIT_POWER_ENABLE) begin
			RX_BYTE <= `RST_RX_BUFFER;
			RX_FULL <= 1'b0;
		end else if (RX_DONE && rx_on && (!RX_FULL || RXB_RD)) begin
			RX_BYTE <= rx_masked;
			RX_FULL <= 1'b1;
		end else if (RXB_RD) begin
			RX_FULL <= 1'b0;
		end
	end

	// Baud clock generator
	baud_gen #(
		.PRE_W(7)
	) u_baud_gen (
		.clk(CLK_SYS),
		.srst(SRST),
		.run(UNIT_POWER_ENABLE),
		.src_sel(SOURCE_SELECT),
		.divisor(divider_reg),
		.ext_clk(ext_s2_reg),
		.baud_clk(BAUD_CLK),
		.baud_tick(BAUD_TICK)
	);

endmodule // uart_status_top
`default_nettype wire

// ===== testbench/uart_status_properties.sv
// Port-level assertions for the serial status block
`timescale 1ns/100ps
`default_nettype none
module uart_status_props (
	input wire CLK_SYS, // clock
	input wire SRST, // reset
	input wire [7:0] RDATA, // read data
	input wire UNIT_POWER_ENABLE, // power
	input wire TRANSMIT_ENABLE_BIT, // tx enable
	input wire RECEIVE_ENABLE_BIT, // rx enable
	input wire CHAR_LEN_8, // length
	input wire TXB_WR, // buffer write
	input wire [7:0] TXB_DATA, // buffer data
	input wire TXB_READY, // room
	input wire TX_VALID, // offer
	input wire [7:0] TX_DATA, // offered byte
	input wire TX_READY, // take
	input wire RX_DONE, // frame end
	input wire [7:0] RX_SHIFT_DATA, // frame data
	input wire RXB_RD, // buffer read
	input wire [7:0] RX_BYTE, // held byte
	input wire RX_FULL, // held flag
	input wire BAUD_TICK // tick
);
	// Enables and the byte a frame should leave behind
	wire rx_on = UNIT_POWER_ENABLE & RECEIVE_ENABLE_BIT;
	wire tx_on = UNIT_POWER_ENABLE & TRANSMIT_ENABLE_BIT;
	wire [7:0] rx_exp = CHAR_LEN_8 ? RX_SHIFT_DATA : {1'b0, RX_SHIFT_DATA[6:0]};
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	property p_reset;
		disable iff (1'b0) SRST |=> RDATA == 8'h00 && !TX_VALID && !RX_FULL;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_rx_take;
		RX_DONE && rx_on && !RX_FULL |=> RX_FULL && RX_BYTE == $past(rx_exp);
	endproperty
	a_rx_take: assert property (p_rx_take) else $error("byte not held");
	property p_overrun;
		RX_DONE && rx_on && RX_FULL && !RXB_RD |=> RX_FULL && $stable(RX_BYTE);
	endproperty
	a_overrun: assert property (p_overrun) else $error("byte overwritten");
	property p_rx_read;
		RXB_RD && !RX_DONE |=> !RX_FULL;
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("full after read");
	property p_power_off;
		!UNIT_POWER_ENABLE |=> !RX_FULL && RX_BYTE == 8'hFF && !BAUD_TICK;
	endproperty
	a_power_off: assert property (p_power_off) else $error("not cleared");
	property p_tx_load;
		TXB_WR && TXB_READY && !TX_VALID && tx_on
			|=> TX_VALID && TX_DATA == $past(TXB_DATA);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("byte not offered");
	property p_tx_hold;
		TX_VALID && !TX_READY && tx_on |=> TX_VALID && $stable(TX_DATA);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("offer dropped");
	property p_tx_flush;
		!tx_on |=> !TX_VALID;
	endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("not flushed");
	property p_tick;
		BAUD_TICK |=> !BAUD_TICK [*7];
	endproperty
	a_tick: assert property (p_tick) else $error("ticks too close");
	// Main scenarios reached
	c_overrun: cover property (RX_DONE && RX_FULL);
	c_take: cover property (TX_VALID && TX_READY);
	c_tick: cover property (BAUD_TICK ##1 !BAUD_TICK);
endmodule // uart_status_props
bind uart_status_top uart_status_props i_props (.*);
`default_nettype wire

// ===== testbench/tx_shifter_model.sv
// Transmit shifter stand-in: takes a byte, sends it, reports frame end
`timescale 1ns/100ps
`default_nettype none
module tx_shifter_model #(
	parameter [7:0] FRAME_CYC = 8'h1E
) (
	input wire clk, // clock
	input wire srst, // reset
	input wire stall, // hold off takes
	input wire tx_valid, // offer
	output wire tx_ready, // take
	output reg shift_done // frame end
);
	reg [7:0] cnt_reg;
	// Ready only when idle, so each byte gets a whole frame time
	assign tx_ready = !stall && cnt_reg == 8'h00 && !shift_done;
	// Frame timer and end pulse
	always @(posedge clk) begin
		if (srst) begin
			cnt_reg <= 8'h00;
			shift_done <= 1'b0;
		end else begin
			shift_done <= cnt_reg == 8'h01;
			if (tx_valid && tx_ready)
				cnt_reg <= FRAME_CYC;
			else if (cnt_reg != 8'h00)
				cnt_reg <= cnt_reg - 8'h01;
		end
	end
endmodule // tx_shifter_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Bench for the serial status block with a shifter model at the far side
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	reg clk = 0, srst = 1, wr = 0, rd = 0, pwr = 1, txe = 0, rxe = 0, len8 = 1;
	reg txb_wr = 0, rx_done = 0, par_bit = 0, stop_bit = 1, mp_bit = 0;
	reg rxb_rd = 0, stall = 1, rd_d = 0, held = 0, id = 0, perr;
	reg ext_pin = 0;
	reg [7:0] q_e;
	wire baud_clk;
	reg [15:0] addr = 16'h0000;
	reg [7:0] wdata = 8'h00, txb_data = 8'h00, rx_data = 8'h00, dexp = 8'hFF;
	reg [7:0] dm;
	reg [1:0] psel = 2'h0, tmode = 2'h0;
	reg [2:0] ssel = 3'h1;
	reg [31:0] r;
	wire [7:0] rdata, tx_data, rx_byte;
	wire txb_ready, tx_valid, tx_ready, shift_done, rx_full, baud_tick;
	int n_errors = 0, num_checks = 0, gap;
	reg [7:0] rd_q[$], tx_q[$];
	uart_status_top i_dut (.CLK_SYS(clk), .SRST(srst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.UNIT_POWER_ENABLE(pwr), .TRANSMIT_ENABLE_BIT(txe),
		.RECEIVE_ENABLE_BIT(rxe), .PARITY_SELECT(psel), .CHAR_LEN_8(len8),
		.TRANSFER_MODE(tmode), .SOURCE_SELECT(ssel), .EXT_CLK_PIN(ext_pin),
		.TXB_WR(txb_wr), .TXB_DATA(txb_data), .TXB_READY(txb_ready),
		.TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready),
		.TX_SHIFT_DONE(shift_done), .RX_DONE(rx_done),
		.RX_SHIFT_DATA(rx_data), .RX_PARITY_BIT(par_bit),
		.RX_STOP_BIT(stop_bit), .RX_MP_BIT(mp_bit), .RXB_RD(rxb_rd),
		.RX_BYTE(rx_byte), .RX_FULL(rx_full), .BAUD_CLK(baud_clk),
		.BAUD_TICK(baud_tick));
	tx_shifter_model i_shift (.clk(clk), .srst(srst), .stall(stall),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .shift_done(shift_done));
	always #25 clk = ~clk;
	// External source clock at half of the system clock
	always @(negedge clk) ext_pin <= ~ext_pin;
	// Results taken off the queues as they appear, one pop per result
	always @(posedge clk) begin
		if (rd_d) begin
			q_e = rd_q.pop_front();
			`CHK(rdata, q_e)
		end
		if (tx_valid && tx_ready) begin
			q_e = tx_q.pop_front();
			`CHK(tx_data, q_e)
		end
		rd_d <= rd;
	end
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task reg_rd(input [15:0] a, input [7:0] e);
		rd_q.push_back(e);
		addr = a;
		rd = 1;
		cyc(1);
		rd = 0;
		cyc(1);
	endtask
	task reg_wr(input [15:0] a, input [7:0] d);
		addr = a;
		wdata = d;
		wr = 1;
		cyc(1);
		wr = 0;
		cyc(1);
	endtask
	task tx_wr(input [7:0] d);
		txb_data = d;
		txb_wr = 1;
		cyc(1);
		txb_wr = 0;
		cyc(1);
	endtask
	// Third tick gap, the first two may be partial
	task tick_gap();
		for (int i = 0; i < 3; i++) begin
			gap = 0;
			do begin
				cyc(1);
				gap++;
			end while (!baud_tick && gap < 4000);
		end
	endtask
	// One frame, expected flags worked out from the settings
	task rx_step();
		r = $urandom;
		dm = len8 ? r[7:0] : {1'b0, r[6:0]};
		perr = psel[1] & (^dm ^ r[8] ^ ~psel[0]);
		if (tmode == 2'h1)
			id = r[10];
		{mp_bit, stop_bit, par_bit, rx_data} = r[10:0];
		rx_done = 1;
		cyc(1);
		rx_done = 0;
		cyc(1);
		if (!held)
			dexp = dm;
		`CHK(rx_byte, dexp)
		reg_rd(16'hFF94, {4'h0, id, perr, ~r[9], held});
		held = 1;
		if (r[11]) begin
			rxb_rd = 1;
			cyc(1);
			rxb_rd = 0;
			cyc(1);
			held = 0;
		end
	endtask
	task final_report();
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(61));
		cyc(6);
		srst = 0;
		cyc(1);
		reg_rd(16'hFF93, 8'h00);
		reg_wr(16'hFF94, 8'hFF);
		reg_rd(16'hFF94, 8'h00);
		reg_rd(16'hFF95, 8'h00);
		reg_rd(16'h0000, 8'h00);
		for (int n = 1; n < 4; n++) begin
			ssel = n[2:0];
			reg_wr(16'hFF93, 8'h07 + n[7:0]);
			reg_rd(16'hFF93, 8'h07 + n[7:0]);
			tick_gap();
			`CHK(gap, (1 << (n + 1)) * (7 + n))
			`CHK(baud_clk, 1'b1)
		end
		// External pin source: one rising edge every two cycles
		ssel = 3'h0;
		reg_wr(16'hFF93, 8'h08);
		tick_gap();
		`CHK(gap, 32)
		rxe = 1;
		cyc(2);
		for (int i = 0; i < 32; i++) begin
			psel = i[1:0];
			len8 = i[2];
			tmode = i[3] ? 2'h0 : 2'h1;
			rx_step();
		end
		pwr = 0;
		cyc(1);
		pwr = 1;
		held = 0;
		id = 0;
		reg_rd(16'hFF94, 8'h00);
		rxe = 0;
		txe = 1;
		cyc(2);
		tx_q.push_back(8'hA5);
		tx_wr(8'hA5);
		reg_rd(16'hFF95, 8'h02);
		tx_q.push_back(8'h3C);
		tx_wr(8'h3C);
		`CHK(txb_ready, 1'b0)
		tx_wr(8'h77);
		stall = 0;
		for (int i = 0; i < 200 && tx_q.size() > 0; i++)
			cyc(1);
		cyc(2);
		reg_rd(16'hFF95, 8'h01);
		cyc(40);
		reg_rd(16'hFF95, 8'h00);
		tx_q.push_back(8'h5A);
		tx_wr(8'h5A);
		cyc(3);
		reg_rd(16'hFF95, 8'h01);
		tx_q.push_back(8'hC3);
		tx_wr(8'hC3);
		reg_rd(16'hFF95, 8'h03);
		cyc(80);
		stall = 1;
		tx_wr(8'h11);
		reg_rd(16'hFF95, 8'h02);
		txe = 0;
		cyc(1);
		reg_rd(16'hFF95, 8'h00);
		cyc(2);
		final_report();
	end
	// Watchdog well beyond the expected run
	initial begin
		#1000000;
		n_errors++;
		final_report();
	end
endmodule // tb_top
`default_nettype wire
